//--- hcm_mailbox.v
// Host command mailbox: APB host side, internal processor side, boot sequencing
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "hcm_map.vh"

module hcm_mailbox #(
  parameter CFG_READ_BIT = 0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        dma_mode,
  output wire        dev_cmd_irq,
  input  wire        dev_cmd_done,
  output wire [7:0]  dev_host_code,
  output wire [7:0]  dev_host_genl,
  output wire [7:0]  dev_host_genh,
  input  wire [4:0]  dev_hdata_idx,
  output reg  [15:0] dev_hdata,
  output wire        dec_start_boot,
  output wire        dec_finish_boot,
  output wire        dec_prog_wr,
  output wire        dec_data_wr,
  output wire [3:0]  dec_boot_count,
  output wire        dec_boot_count_bad,
  output wire        dec_reg_wr,
  output wire        dec_reg_rd,
  output wire        dec_cfg_ch,
  output wire        dec_cfg_ml,
  output wire [31:0] cfg_word,
  output wire [7:0]  ml_mode,
  output wire [15:0] ml_norm_addr,
  output wire [15:0] ml_bcast_addr,
  output wire        sub_port,
  output wire [2:0]  sub_ch_2m,
  output wire [3:0]  sub_ch_4m,
  output wire [1:0]  exp_sel,
  output wire [2:0]  exp_ch,
  output wire        exp_sel_bad,
  input  wire        dev_ind_we,
  input  wire [4:0]  dev_ind_idx,
  input  wire [15:0] dev_ind_data,
  input  wire        dev_ind_gen_we,
  input  wire [7:0]  dev_ind_genl,
  input  wire [7:0]  dev_ind_genh,
  input  wire        dev_ind_code_we,
  input  wire [7:0]  dev_ind_code,
  input  wire [15:0] dev_fw_version,
  input  wire        dev_boot_err,
  input  wire [1:0]  dev_boot_err_code,
  output wire        ind_busy,
  output reg         dev_ind_refused,
  output wire [1:0]  boot_phase
);

  // Host-to-device mailbox
  reg  [7:0]  hcode_r;
  reg         hbusy_r;
  reg  [7:0]  hgenl_r;
  reg  [7:0]  hgenh_r;
  reg  [15:0] hdata_r [0:31];
  // Device-to-host mailbox
  reg  [7:0]  icode_r;
  reg         ibusy_r;
  reg  [7:0]  igenl_r;
  reg  [7:0]  igenh_r;
  reg  [15:0] idata_r [0:31];
  // Boot sequencing and pending automatic indications
  reg  [1:0]  phase_r;
  reg         post_pend_r;
  reg         err_pend_r;
  reg  [1:0]  err_code_r;
  reg         cfg_rd_pend_r;
  wire        acc;
  wire        wr;
  wire        setup;
  wire [4:0]  blk;
  wire [4:0]  widx;
  wire        idx_ok;
  wire        hit_hdata;
  wire        hit_idata;
  reg         reg_hit;
  reg         wr_refuse;
  wire        h_wr_code;
  wire        h_wr_genl;
  wire        h_wr_genh;
  wire        h_wr_data;
  wire        h_clr_ibusy;
  wire        auto_post;
  reg  [7:0]  auto_code;
  wire        dev_code_ok;
  wire        dev_post;
  wire        cmd_finish_done;
  integer     i;

  // Merge a write into a 16-bit register under the two low byte strobes
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Data word index legal for the current mailbox size
  function idx_legal;
    input [4:0] idx;
    input       dma;
    begin
      idx_legal = ({1'b0, idx} < (dma ? `HCM_NDATA_SPLIT : `HCM_NDATA_FULL));
    end
  endfunction

  // APB phase decode; a low clock enable holds the access in wait
  assign acc   = psel & penable & ce;
  assign setup = psel & ~penable & ce;
  assign wr    = acc & pwrite;
  assign pready = ce;
  assign blk   = paddr[11:7];
  assign widx  = paddr[6:2];
  assign idx_ok = idx_legal(widx, dma_mode);
  assign hit_hdata = (blk == `HCM_BLK_HDATA) & idx_ok;
  assign hit_idata = (blk == `HCM_BLK_IDATA) & idx_ok;
  // Address decode for the single registers
  always @*
  begin
    case (paddr)
      `HCM_OFF_HCODE, `HCM_OFF_HBUSY, `HCM_OFF_HGENL, `HCM_OFF_HGENH,
      `HCM_OFF_ICODE, `HCM_OFF_IBUSY, `HCM_OFF_IGENL, `HCM_OFF_IGENH,
      `HCM_OFF_STAT: reg_hit = 1'b1;
      default:       reg_hit = hit_hdata | hit_idata;
    endcase
  end

  always @*
  begin
    wr_refuse = 1'b0;
    if (hbusy_r && (paddr == `HCM_OFF_HCODE || paddr == `HCM_OFF_HGENL ||
        paddr == `HCM_OFF_HGENH || hit_hdata))
      wr_refuse = 1'b1;
    if (paddr == `HCM_OFF_HBUSY || paddr == `HCM_OFF_ICODE || paddr == `HCM_OFF_IGENL ||
        paddr == `HCM_OFF_IGENH || paddr == `HCM_OFF_STAT || hit_idata)
      wr_refuse = 1'b1;
  end

  // Unmapped accesses, and writes to read-only or busy-blocked registers, answer with an error
  assign pslverr = acc & (~reg_hit | (pwrite & wr_refuse));
  assign h_wr_code   = wr & ~wr_refuse & (paddr == `HCM_OFF_HCODE) & pstrb[0];
  assign h_wr_genl   = wr & ~wr_refuse & (paddr == `HCM_OFF_HGENL) & pstrb[0];
  assign h_wr_genh   = wr & ~wr_refuse & (paddr == `HCM_OFF_HGENH) & pstrb[0];
  assign h_wr_data   = wr & ~wr_refuse & hit_hdata;
  // Writing zero to the busy bit releases the indication mailbox
  assign h_clr_ibusy = wr & (paddr == `HCM_OFF_IBUSY) & pstrb[0] & ~pwdata[0];
  // Read data captured in the setup cycle so prdata comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `HCM_OFF_HCODE: prdata <= {24'h00_0000, hcode_r};
        `HCM_OFF_HBUSY: prdata <= {31'h0000_0000, hbusy_r};
        `HCM_OFF_HGENL: prdata <= {24'h00_0000, hgenl_r};
        `HCM_OFF_HGENH: prdata <= {24'h00_0000, hgenh_r};
        `HCM_OFF_ICODE: prdata <= {24'h00_0000, icode_r};
        `HCM_OFF_IBUSY: prdata <= {31'h0000_0000, ibusy_r};
        `HCM_OFF_IGENL: prdata <= {24'h00_0000, igenl_r};
        `HCM_OFF_IGENH: prdata <= {24'h00_0000, igenh_r};
        `HCM_OFF_STAT:  prdata <= {28'h000_0000, cfg_rd_pend_r, dma_mode, phase_r};
        default:
        begin
          if (hit_hdata)
            prdata <= {16'h0000, hdata_r[widx]};
          else if (hit_idata)
            prdata <= {16'h0000, idata_r[widx]};
          else
            prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Host mailbox: parameters, code and busy flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcode_r <= 8'h00;
      hbusy_r <= 1'b0;
      hgenl_r <= 8'h00;
      hgenh_r <= 8'h00;
      for (i = 0; i < 32; i = i + 1)
        hdata_r[i] <= 16'h0000;
    end
    else if (ce)
    begin
      if (h_wr_genl)
        hgenl_r <= pwdata[7:0];
      if (h_wr_genh)
        hgenh_r <= pwdata[7:0];
      if (h_wr_data)
        hdata_r[widx] <= merge16(hdata_r[widx], pwdata[15:0], pstrb[1:0]);
      if (h_wr_code)
        hcode_r <= pwdata[7:0];
      // code write sets busy; set wins over a simultaneous done
      if (h_wr_code)
        hbusy_r <= 1'b1;
      else if (dev_cmd_done)
        hbusy_r <= 1'b0;
    end
  end

  // Host busy is the interrupt toward the internal processor
  assign dev_cmd_irq   = hbusy_r;
  assign dev_host_code = hcode_r;
  assign dev_host_genl = hgenl_r;
  assign dev_host_genh = hgenh_r;
  // Registered view of one host data word for the internal processor
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dev_hdata <= 16'h0000;
    else if (ce)
      dev_hdata <= hdata_r[dev_hdata_idx];
  end
  assign dec_start_boot     = (hcode_r == `HCM_CMD_START);
  assign dec_finish_boot    = (hcode_r == `HCM_CMD_FINISH);
  assign dec_prog_wr        = (hcode_r[7:4] == `HCM_CMD_PROG_HI);
  assign dec_data_wr        = (hcode_r[7:4] == `HCM_CMD_DATA_HI);
  assign dec_boot_count     = hcode_r[3:0];
  assign dec_boot_count_bad = (dec_prog_wr | dec_data_wr) & (hcode_r[3:0] == 4'h0);
  // register access; count in general low, address in data0
  assign dec_reg_wr = (hcode_r == `HCM_CMD_REG_WR);
  assign dec_reg_rd = (hcode_r == `HCM_CMD_REG_RD);
  assign dec_cfg_ch = (hcode_r == `HCM_CMD_CFG_CH);
  assign cfg_word   = {hdata_r[0][15:8], hdata_r[0][7:0], hdata_r[1][15:8], hdata_r[1][7:0]};
  assign dec_cfg_ml    = (hcode_r == `HCM_CMD_CFG_ML);
  assign ml_mode       = hdata_r[0][7:0];
  assign ml_norm_addr  = hdata_r[1];
  assign ml_bcast_addr = hdata_r[2];
  assign sub_port  = hgenl_r[3];
  assign sub_ch_2m = hgenl_r[2:0];
  assign sub_ch_4m = hgenl_r[3:0];
  assign exp_sel     = hgenl_r[4:3];
  assign exp_ch      = hgenl_r[2:0];
  assign exp_sel_bad = (hgenl_r[4:3] == 2'h3);
  // A finish-boot completion moves the boot phase on
  assign cmd_finish_done = ce & dev_cmd_done & hbusy_r & dec_finish_boot &
                           (phase_r != `HCM_PH_INIT);
  // Hardware indications take the mailbox first, when it is free
  assign auto_post = ~ibusy_r & (post_pend_r | err_pend_r);
  always @*
  begin
    if (err_pend_r)
      auto_code = {`HCM_IND_ERR_HI, err_code_r};
    else
    begin
      case (phase_r)
        `HCM_PH_PROG: auto_code = `HCM_IND_PROG_RDY;
        `HCM_PH_DATA: auto_code = `HCM_IND_DATA_RDY;
        default:      auto_code = `HCM_IND_FW;
      endcase
    end
  end

  assign dev_code_ok = (dev_ind_code != `HCM_IND_CFG_DONE) | cfg_rd_pend_r;
  assign dev_post    = dev_ind_code_we & ~ibusy_r & ~auto_post & dev_code_ok;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_r       <= `HCM_PH_PROG;
      post_pend_r   <= 1'b1;
      err_pend_r    <= 1'b0;
      err_code_r    <= 2'h0;
      cfg_rd_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_finish_done)
      begin
        phase_r     <= (phase_r == `HCM_PH_PROG) ? `HCM_PH_DATA : `HCM_PH_INIT;
        post_pend_r <= 1'b1;
      end
      else if (auto_post && !err_pend_r)
        post_pend_r <= 1'b0;
      // A new error wins over the one being posted this cycle
      if (dev_boot_err)
      begin
        err_pend_r <= 1'b1;
        err_code_r <= dev_boot_err_code;
      end
      else if (auto_post)
        err_pend_r <= 1'b0;
      if (ce && dev_cmd_done && hbusy_r && dec_cfg_ch && cfg_word[CFG_READ_BIT])
        cfg_rd_pend_r <= 1'b1;
      else if (dev_post && dev_ind_code == `HCM_IND_CFG_DONE)
        cfg_rd_pend_r <= 1'b0;
    end
  end

  assign boot_phase = phase_r;
  // Indication mailbox: parameters, code and busy flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      icode_r <= 8'h00;
      ibusy_r <= 1'b0;
      igenl_r <= 8'h00;
      igenh_r <= 8'h00;
      dev_ind_refused <= 1'b0;
      for (i = 0; i < 32; i = i + 1)
        idata_r[i] <= 16'h0000;
    end
    else if (ce)
    begin
      if (dev_ind_gen_we && !ibusy_r)
      begin
        igenl_r <= dev_ind_genl;
        igenh_r <= dev_ind_genh;
      end
      if (dev_ind_we && !ibusy_r && idx_legal(dev_ind_idx, dma_mode))
        idata_r[dev_ind_idx] <= dev_ind_data;
      if (auto_post && !err_pend_r && phase_r == `HCM_PH_INIT)
        idata_r[0] <= dev_fw_version;
      if (auto_post)
        icode_r <= auto_code;
      else if (dev_post)
        icode_r <= dev_ind_code;
      if (auto_post || dev_post)
        ibusy_r <= 1'b1;
      else if (h_clr_ibusy)
        ibusy_r <= 1'b0;
      // Refused code writes pulse so firmware can retry
      dev_ind_refused <= dev_ind_code_we & ~dev_post;
    end
  end

  assign ind_busy = ibusy_r;
endmodule

//--- hcm_map.vh
// Register offsets, command and indication codes for the host command mailbox
`ifndef HCM_MAP_VH
`define HCM_MAP_VH

`define HCM_ADDR_W        12
`define HCM_OFF_HCODE     12'h000
`define HCM_OFF_HBUSY     12'h004
`define HCM_OFF_HGENL     12'h008
`define HCM_OFF_HGENH     12'h00c
`define HCM_OFF_ICODE     12'h010
`define HCM_OFF_IBUSY     12'h014
`define HCM_OFF_IGENL     12'h018
`define HCM_OFF_IGENH     12'h01c
`define HCM_OFF_STAT      12'h020
`define HCM_BLK_HDATA     5'h01
`define HCM_BLK_IDATA     5'h02

`define HCM_NDATA_FULL    6'h20
`define HCM_NDATA_SPLIT   6'h10

`define HCM_CMD_START     8'h55
`define HCM_CMD_FINISH    8'h1f
`define HCM_CMD_PROG_HI   4'ha
`define HCM_CMD_DATA_HI   4'he
`define HCM_CMD_REG_WR    8'h01
`define HCM_CMD_REG_RD    8'h02
`define HCM_CMD_CFG_CH    8'h03
`define HCM_CMD_CFG_ML    8'h14

`define HCM_IND_PROG_RDY  8'h1f
`define HCM_IND_DATA_RDY  8'hef
`define HCM_IND_ERR_HI    6'h1c
`define HCM_IND_FW        8'h00
`define HCM_IND_REG_RD    8'h01
`define HCM_IND_CFG_DONE  8'h02

`define HCM_PH_PROG       2'h0
`define HCM_PH_DATA       2'h1
`define HCM_PH_INIT       2'h2

`endif

//--- hcm_mailbox_assertions.sv
// Checker watching the host command mailbox ports
`timescale 1ns/1ns
module hcm_mailbox_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        dma_mode,
  input wire logic        dev_cmd_irq,
  input wire logic        dev_cmd_done,
  input wire logic        dev_ind_code_we,
  input wire logic        ind_busy,
  input wire logic        dev_ind_refused,
  input wire logic [1:0]  boot_phase,
  input wire logic [7:0]  dev_host_genl,
  input wire logic [1:0]  exp_sel,
  input wire logic        exp_sel_bad
);
  // Completed host write; only the access edge counts
  wire hw = psel && penable && pwrite && ce;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_code_busy;
    hw && paddr == 12'h000 && !pslverr |=> dev_cmd_irq;
  endproperty
  a_code_busy: assert property (p_code_busy) else $error("host busy not set");
  property p_done_clr;
    dev_cmd_irq && dev_cmd_done && ce && !(hw && paddr == 12'h000) |=> !dev_cmd_irq;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("host busy not cleared");
  property p_busy_ref;
    hw && dev_cmd_irq && paddr == 12'h000 |-> pslverr;
  endproperty
  a_busy_ref: assert property (p_busy_ref) else $error("code write while busy taken");
  property p_dma_ref;
    psel && penable && ce && dma_mode && paddr[11:6] == 6'h03 |-> pslverr;
  endproperty
  a_dma_ref: assert property (p_dma_ref) else $error("upper data word open in split mode");
  property p_ind_hold;
    ind_busy && !(hw && paddr == 12'h014 && !pwdata[0]) |=> ind_busy;
  endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indication busy dropped alone");
  property p_ind_ref;
    dev_ind_code_we && ind_busy && ce |=> dev_ind_refused;
  endproperty
  a_ind_ref: assert property (p_ind_ref) else $error("busy indication post not refused");
  property p_phase;
    !$stable(boot_phase) |-> boot_phase == $past(boot_phase) + 2'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("boot phase jumped");
  property p_exp;
    exp_sel == dev_host_genl[4:3] && exp_sel_bad == (dev_host_genl[4:3] == 2'h3);
  endproperty
  a_exp: assert property (p_exp) else $error("expander select wrong");
endmodule

bind hcm_mailbox hcm_mailbox_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .dma_mode, .dev_cmd_irq, .dev_cmd_done, .dev_ind_code_we, .ind_busy, .dev_ind_refused, .boot_phase,
  .dev_host_genl, .exp_sel, .exp_sel_bad);

//--- hcm_dev_model.sv
// Internal processor model answering host commands after a set delay
`timescale 1ns/1ns
module hcm_dev_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       dev_cmd_irq,
  input  wire logic [7:0] lat,
  output logic            dev_cmd_done
);
  logic [7:0] cnt_r;

  // release after work
  // One-cycle done; the hold-off cycle stops a second pulse before busy drops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 8'h00;
      dev_cmd_done <= 1'b0;
    end
    else
    begin
      dev_cmd_done <= 1'b0;
      if (dev_cmd_irq && !dev_cmd_done)
        if (cnt_r >= lat)
        begin
          dev_cmd_done <= 1'b1;
          cnt_r <= 8'h00;
        end
        else
          cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the host command mailbox
`timescale 1ns/1ns
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, dma_mode, dev_cmd_done, err;
  logic        dev_ind_we, dev_ind_gen_we, dev_ind_code_we, dev_boot_err, pready, pslverr, dev_cmd_irq;
  logic        ind_busy, dev_ind_refused, sub_port, exp_sel_bad, dec_boot_count_bad;
  logic        dec_start_boot, dec_finish_boot, dec_prog_wr, dec_data_wr, dec_reg_wr, dec_reg_rd, dec_cfg_ch, dec_cfg_ml;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_word, rd;
  logic [15:0] dev_ind_data, dev_fw_version, dev_hdata, ml_bcast_addr, ml_norm_addr;
  logic [7:0]  dev_ind_genl, dev_ind_genh, dev_ind_code, lat, dev_host_code, dev_host_genl, dev_host_genh, ml_mode;
  logic [4:0]  dev_hdata_idx, dev_ind_idx;
  logic [3:0]  pstrb, sub_ch_4m, dec_boot_count;
  logic [2:0]  exp_ch, sub_ch_2m;
  logic [1:0]  dev_boot_err_code, boot_phase, exp_sel;
  int          bad_count, n_compared;

  hcm_mailbox dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .dma_mode, .dev_cmd_irq, .dev_cmd_done, .dev_host_code, .dev_host_genl, .dev_host_genh, .dev_hdata_idx, .dev_hdata,
    .dec_start_boot, .dec_finish_boot, .dec_prog_wr, .dec_data_wr, .dec_boot_count, .dec_boot_count_bad, .dec_reg_wr,
    .dec_reg_rd, .dec_cfg_ch, .dec_cfg_ml, .cfg_word, .ml_mode, .ml_norm_addr, .ml_bcast_addr, .sub_port,
    .sub_ch_2m, .sub_ch_4m, .exp_sel, .exp_ch, .exp_sel_bad, .dev_ind_we, .dev_ind_idx, .dev_ind_data,
    .dev_ind_gen_we, .dev_ind_genl, .dev_ind_genh, .dev_ind_code_we, .dev_ind_code, .dev_fw_version, .dev_boot_err,
    .dev_boot_err_code, .ind_busy, .dev_ind_refused, .boot_phase);
  hcm_dev_model u_dev (.pclk, .presetn, .dev_cmd_irq, .lat, .dev_cmd_done);

  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wrc(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk(err, ee);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Waits for host busy low (0) or indication busy high (1), bounded
  task waitc(input logic ind);
    int n;
    n = 0;
    // Let the edge that launched the request update the flags first
    @(posedge pclk);
    while ((ind ? ind_busy : !dev_cmd_irq) !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
      bad_count++;
  endtask

  // Device side post: data first, then params, code last
  task post(input logic [7:0] c, input logic [7:0] g, input logic [15:0] d, input logic rf);
    @(posedge pclk);
    dev_ind_we <= 1'b1;
    dev_ind_data <= d;
    @(posedge pclk);
    dev_ind_we <= 1'b0;
    dev_ind_gen_we <= 1'b1;
    dev_ind_genl <= g;
    dev_ind_genh <= ~g;
    @(posedge pclk);
    dev_ind_gen_we <= 1'b0;
    dev_ind_code_we <= 1'b1;
    dev_ind_code <= c;
    @(posedge pclk);
    dev_ind_code_we <= 1'b0;
    @(negedge pclk);
    chk(dev_ind_refused, rf);
  endtask

  task t_boot_ready;
    repeat (2) @(posedge pclk);
    chk(ind_busy, 1'b1);
    rdc(12'h010, 32'h1f);
    chk(boot_phase, 2'h0);
  endtask

  task t_host_cmd;
    lat <= 8'd12;
    wrc(12'h080, 32'h1234, 1'b0);
    wrc(12'h008, 32'h1d, 1'b0);
    wrc(12'h000, 32'h55, 1'b0);
    rdc(12'h004, 32'h1);
    wrc(12'h00c, 32'h7, 1'b1);
    chk({sub_port, sub_ch_4m, exp_sel, exp_ch, exp_sel_bad}, 11'h77b);
    chk(sub_ch_2m, 3'h5);
    chk(dev_hdata, 16'h1234);
    waitc(1'b0);
    rdc(12'h004, 32'h0);
  endtask

  task t_boot;
    wrc(12'h014, 32'h0, 1'b0);
    dev_boot_err <= 1'b1;
    dev_boot_err_code <= 2'h2;
    @(posedge pclk);
    dev_boot_err <= 1'b0;
    waitc(1'b1);
    rdc(12'h010, 32'h72);
    lat <= 8'd0;
    for (int i = 1; i <= 2; i++)
    begin
      wrc(12'h014, 32'h0, 1'b0);
      wrc(12'h000, 32'h1f, 1'b0);
      waitc(1'b0);
      waitc(1'b1);
      chk(boot_phase, i);
      rdc(12'h010, (i == 1) ? 32'hef : 32'h0);
    end
    rdc(12'h100, 32'h0217);
  endtask

  task t_decode;
    logic [7:0] codes [8];
    codes = '{8'h55, 8'h1f, 8'ha5, 8'he3, 8'h01, 8'h02, 8'h03, 8'h14};
    wrc(12'h084, 32'h5678, 1'b0);
    wrc(12'h088, 32'h9abc, 1'b0);
    dev_hdata_idx <= 5'h01;
    for (int i = 0; i < 8; i++)
    begin
      wrc(12'h000, codes[i], 1'b0);
      @(posedge pclk);
      chk(dev_host_code, codes[i]);
      chk({dec_start_boot, dec_finish_boot, dec_prog_wr, dec_data_wr, dec_reg_wr, dec_reg_rd, dec_cfg_ch,
           dec_cfg_ml}, 8'h80 >> i);
      waitc(1'b0);
    end
    chk(cfg_word, 32'h12345678);
    chk({ml_mode, ml_bcast_addr}, 24'h349abc);
    chk(ml_norm_addr, 16'h5678);
    chk(dev_hdata, 16'h5678);
    wrc(12'h000, 32'ha0, 1'b0);
    @(posedge pclk);
    chk({dec_boot_count_bad, dec_boot_count}, 5'h10);
    waitc(1'b0);
  endtask

  task t_ind;
    wrc(12'h014, 32'h0, 1'b0);
    post(8'h01, 8'h03, 16'hbeef, 1'b0);
    chk(ind_busy, 1'b1);
    rdc(12'h010, 32'h1);
    rdc(12'h018, 32'h3);
    rdc(12'h01c, 32'hfc);
    rdc(12'h100, 32'hbeef);
    post(8'h02, 8'h00, 16'h0, 1'b1);
    wrc(12'h010, 32'h5, 1'b1);
    wrc(12'h014, 32'h0, 1'b0);
    rdc(12'h014, 32'h0);
    // Completion code refused until a config command asked for it
    post(8'h02, 8'h00, 16'h0, 1'b1);
    wrc(12'h084, 32'h1, 1'b0);
    wrc(12'h000, 32'h03, 1'b0);
    waitc(1'b0);
    rdc(12'h020, 32'ha);
    post(8'h02, 8'h00, 16'h0, 1'b0);
    rdc(12'h010, 32'h2);
  endtask

  task t_dma;
    dma_mode <= 1'b1;
    wrc(12'h0c0, 32'h1, 1'b1);
    rdc(12'h020, 32'h6);
    dma_mode <= 1'b0;
    wrc(12'h0fc, 32'h1, 1'b0);
    rdc(12'h0fc, 32'h1);
    wrc(12'h300, 32'h0, 1'b1);
  endtask

  // Low clock enable stalls a write until it returns
  task t_ce;
    ce <= 1'b0;
    fork
      wrc(12'h00c, 32'h5a, 1'b0);
      begin
        repeat (4) @(posedge pclk);
        chk(pready, 1'b0);
        ce <= 1'b1;
      end
    join
    rdc(12'h00c, 32'h5a);
    chk(dev_host_genh, 8'h5a);
  endtask

  task tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence; version value is arbitrary
  initial
  begin
    {presetn, psel, penable, pwrite, dma_mode, dev_ind_we, dev_ind_gen_we, dev_ind_code_we, dev_boot_err} = '0;
    {paddr, pwdata, dev_ind_data, dev_ind_genl, dev_ind_genh, dev_ind_code, dev_hdata_idx, dev_ind_idx} = '0;
    dev_boot_err_code = 2'h0;
    ce = 1'b1;
    pstrb = 4'hf;
    dev_fw_version = 16'h0217;
    lat = 8'h00;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_boot_ready;
    t_host_cmd;
    t_boot;
    t_decode;
    t_ind;
    t_dma;
    t_ce;
    tally_and_finish;
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #2000000;
    bad_count++;
    tally_and_finish;
  end
endmodule
